// [rtl/rpp_pkg.sv]
// constants, types and decode helpers for the rom program patch unit
// What this block does
// - six patch banks, each replacing one aligned two-byte rom word, twelve bytes total.
// - only reads inside the on-chip rom region are compared and substituted.
// - all banks identical, each with its own compare address and patch word.
// - each bank has three compare bytes and two patch word bytes.
// - first compare byte holds address bits 7..1; its bit 0 is not implemented.
// - second compare byte holds address bits 15..8.
// - third compare byte holds address bits 23..16, giving a 23-bit compare of address bits 23..1.
// - low patch byte supplies patch word bits 7..0.
// - high patch byte supplies patch word bits 15..8.
// - bank registers are write-only; software uses plain full-byte writes only.
// - bit 0 of a first compare byte reads undefined; here it reads zero.
// - bank n registers at 0400h plus 8n; compare +0..+2, patch word +4, +5.
// - every compare and patch bit resets to zero.
package rpp_pkg;

    // ==========================================
    // bank geometry and register map
    localparam int          NUM_BANKS   = 6;
    localparam int          BANK_IDX_W  = 3;
    localparam logic [15:0] BANK_BASE   = 16'h0400;
    localparam logic [15:0] BANK_STRIDE = 16'h0008;
    localparam logic [15:0] BANK_END    = 16'h0430;
    localparam logic [2:0]  FLD_ADDR_LO = 3'h0;
    localparam logic [2:0]  FLD_ADDR_MI = 3'h1;
    localparam logic [2:0]  FLD_ADDR_HI = 3'h2;
    localparam logic [2:0]  FLD_WORD_LO = 3'h4;
    localparam logic [2:0]  FLD_WORD_HI = 3'h5;

    localparam logic [15:0] BANK0_MATCH_ADDR_LOW  = 16'h0400;
    localparam logic [15:0] BANK0_MATCH_ADDR_MID  = 16'h0401;
    localparam logic [15:0] BANK0_MATCH_ADDR_HIGH = 16'h0402;
    localparam logic [15:0] BANK0_PATCH_WORD_LOW  = 16'h0404;
    localparam logic [15:0] BANK0_PATCH_WORD_HIGH = 16'h0405;
    localparam logic [15:0] BANK1_MATCH_ADDR_LOW  = 16'h0408;
    localparam logic [15:0] BANK1_MATCH_ADDR_MID  = 16'h0409;
    localparam logic [15:0] BANK1_MATCH_ADDR_HIGH = 16'h040a;
    localparam logic [15:0] BANK1_PATCH_WORD_LOW  = 16'h040c;
    localparam logic [15:0] BANK5_MATCH_ADDR_HIGH = 16'h042a;
    localparam logic [15:0] BANK5_PATCH_WORD_HIGH = 16'h042d;

    // hit status, write one to clear
    localparam logic [15:0] HIT_STATUS_ADDR = 16'h0440;

    // ==========================================
    // on-chip rom region and reset values
    localparam logic [23:0] ROM_FIRST  = 24'hff0000;
    localparam logic [23:0] ROM_LAST   = 24'hffffff;
    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [7:0]  READ_ZERO  = 8'h00;

    // ==========================================
    // carriers
    typedef struct packed
    {
        logic [23:1] match_addr;
        logic [15:0] patch_word;
    } rpp_bank_t;

    typedef struct packed
    {
        logic        rd;
        logic [23:0] addr;
    } rpp_fetch_t;

    localparam rpp_bank_t RESET_BANK = '0;

    // ==========================================
    // decode helpers
    function automatic logic is_bank_addr(input logic [15:0] a);
        return (a >= BANK_BASE) && (a < BANK_END);
    endfunction

    function automatic logic [BANK_IDX_W-1:0] bank_of(input logic [15:0] a);
        logic [15:0] d;
        d = a - BANK_BASE;
        return d[5:3];
    endfunction

    function automatic logic in_rom(input logic [23:0] a);
        return (a >= ROM_FIRST) && (a <= ROM_LAST);
    endfunction

endpackage

// [rtl/rpp_patch_sel.sv]
// lowest-numbered-bank priority selector for patch matches
`timescale 1ns/1ps
module rpp_patch_sel
(
    input  wire logic [rpp_pkg::NUM_BANKS-1:0]         match,
    input  wire logic [rpp_pkg::NUM_BANKS-1:0][15:0]   words,
    output logic                                       hit,
    output logic [rpp_pkg::BANK_IDX_W-1:0]             index,
    output logic [15:0]                                word
);

    // ==========================================
    // scan from the top so the lowest match is left standing
    always_comb
    begin
        hit   = 1'b0;
        index = '0;
        word  = 16'h0000;
        for (int i = rpp_pkg::NUM_BANKS - 1; i >= 0; i--)
        begin
            if (match[i])
            begin
                hit   = 1'b1;
                index = rpp_pkg::BANK_IDX_W'(i);
                word  = words[i];
            end
        end
    end

endmodule

// [rtl/rpp_patch_unit.sv]
// rom program patch unit: bank registers, address compare and word substitution
`timescale 1ns/1ps
module rpp_patch_unit
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    input  wire logic [15:0]           reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [7:0]                 reg_rdata,
    input  wire rpp_pkg::rpp_fetch_t   fetch,
    input  wire logic [15:0]           rom_rdata,
    output logic                       code_valid,
    output logic [15:0]                code_rdata,
    output logic                       patch_hit,
    output logic [2:0]                 patch_bank
);

    // ==========================================
    // bank storage
    rpp_pkg::rpp_bank_t                      bank [rpp_pkg::NUM_BANKS];
    logic                                    wr_bank_sel;
    logic [rpp_pkg::BANK_IDX_W-1:0]          wr_bank_idx;
    logic [2:0]                              wr_field;
    logic [rpp_pkg::NUM_BANKS-1:0]           match;
    logic [rpp_pkg::NUM_BANKS-1:0][15:0]     words;
    logic                                    fetch_in_rom;
    logic                                    sel_hit;
    logic [rpp_pkg::BANK_IDX_W-1:0]          sel_index;
    logic [15:0]                             sel_word;
    logic [rpp_pkg::NUM_BANKS-1:0]           hit_flags;
    logic [rpp_pkg::NUM_BANKS-1:0]           next_hit_flags;
    logic [rpp_pkg::NUM_BANKS-1:0]           hit_set;
    logic                                    status_wr;
    logic                                    wr_seen;

    // ==========================================
    // write decode
    always_comb
    begin
        wr_bank_sel = reg_wr && rpp_pkg::is_bank_addr(reg_addr);
        wr_bank_idx = rpp_pkg::bank_of(reg_addr);
        wr_field    = reg_addr[2:0];
        status_wr   = reg_wr && (reg_addr == rpp_pkg::HIT_STATUS_ADDR);
    end

    // ==========================================
    // bank registers, written as whole bytes only
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < rpp_pkg::NUM_BANKS; i++)
            begin
                bank[i] <= rpp_pkg::RESET_BANK;
            end
        end
        else if (wr_bank_sel)
        begin
            for (int i = 0; i < rpp_pkg::NUM_BANKS; i++)
            begin
                if (wr_bank_idx == rpp_pkg::BANK_IDX_W'(i))
                begin
                    case (wr_field)
                        rpp_pkg::FLD_ADDR_LO:
                        begin
                            bank[i].match_addr[7:1] <= reg_wdata[7:1];
                        end
                        rpp_pkg::FLD_ADDR_MI:
                        begin
                            bank[i].match_addr[15:8] <= reg_wdata;
                        end
                        rpp_pkg::FLD_ADDR_HI:
                        begin
                            bank[i].match_addr[23:16] <= reg_wdata;
                        end
                        rpp_pkg::FLD_WORD_LO:
                        begin
                            bank[i].patch_word[7:0] <= reg_wdata;
                        end
                        rpp_pkg::FLD_WORD_HI:
                        begin
                            bank[i].patch_word[15:8] <= reg_wdata;
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
        end
    end

    // ==========================================
    // register read port: bank registers read back zero
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= rpp_pkg::READ_ZERO;
        end
        else if (reg_rd && (reg_addr == rpp_pkg::HIT_STATUS_ADDR))
        begin
            reg_rdata <= {2'b00, hit_flags};
        end
        else
        begin
            reg_rdata <= rpp_pkg::READ_ZERO;
        end
    end

    // ==========================================
    // address compare, one comparator per bank
    always_comb
    begin
        fetch_in_rom = rpp_pkg::in_rom(fetch.addr);
        for (int i = 0; i < rpp_pkg::NUM_BANKS; i++)
        begin
            match[i] = fetch_in_rom && (fetch.addr[23:1] == bank[i].match_addr);
            words[i] = bank[i].patch_word;
        end
    end

    rpp_patch_sel u_sel
    (
        .match (match),
        .words (words),
        .hit   (sel_hit),
        .index (sel_index),
        .word  (sel_word)
    );

    // ==========================================
    // fetch answer, same latency patched or not
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            code_valid <= 1'b0;
        end
        else
        begin
            code_valid <= fetch.rd;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            code_rdata <= 16'h0000;
            patch_hit  <= 1'b0;
            patch_bank <= 3'h0;
        end
        else if (fetch.rd)
        begin
            code_rdata <= sel_hit ? sel_word : rom_rdata;
            patch_hit  <= sel_hit;
            patch_bank <= sel_index;
        end
    end

    // ==========================================
    // sticky hit flags, a new hit beats a clear
    always_comb
    begin
        hit_set = '0;
        if (fetch.rd && sel_hit)
        begin
            hit_set[sel_index] = 1'b1;
        end
        next_hit_flags = hit_flags;
        if (status_wr)
        begin
            next_hit_flags = next_hit_flags & ~reg_wdata[rpp_pkg::NUM_BANKS-1:0];
        end
        next_hit_flags = next_hit_flags | hit_set;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hit_flags <= '0;
        end
        else
        begin
            hit_flags <= next_hit_flags;
        end
    end

    // ==========================================
    // helper: any bank write since reset
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_seen <= 1'b0;
        end
        else if (wr_bank_sel)
        begin
            wr_seen <= 1'b1;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (!rst_b);

    reset_banks_zero_a: assert property (
        !wr_seen |-> (bank[0] == rpp_pkg::RESET_BANK) && (bank[5] == rpp_pkg::RESET_BANK)
    )
    else $error("bank not zero before first write");

    addr_low_store_a: assert property (
        reg_wr && (reg_addr == rpp_pkg::BANK0_MATCH_ADDR_LOW)
        |=> bank[0].match_addr[7:1] == $past(reg_wdata[7:1])
    )
    else $error("bank0 low compare byte not stored");

    addr_mid_store_a: assert property (
        reg_wr && (reg_addr == rpp_pkg::BANK1_MATCH_ADDR_MID)
        |=> bank[1].match_addr[15:8] == $past(reg_wdata)
    )
    else $error("bank1 middle compare byte not stored");

    addr_high_store_a: assert property (
        reg_wr && (reg_addr == rpp_pkg::BANK5_MATCH_ADDR_HIGH)
        |=> bank[5].match_addr[23:16] == $past(reg_wdata)
    )
    else $error("bank5 high compare byte not stored");

    word_low_store_a: assert property (
        reg_wr && (reg_addr == rpp_pkg::BANK1_PATCH_WORD_LOW)
        |=> bank[1].patch_word[7:0] == $past(reg_wdata)
    )
    else $error("bank1 low patch byte not stored");

    word_high_store_a: assert property (
        reg_wr && (reg_addr == rpp_pkg::BANK5_PATCH_WORD_HIGH)
        |=> bank[5].patch_word[15:8] == $past(reg_wdata)
    )
    else $error("bank5 high patch byte not stored");

    bank_read_zero_a: assert property (
        reg_rd && rpp_pkg::is_bank_addr(reg_addr) |=> reg_rdata == rpp_pkg::READ_ZERO
    )
    else $error("bank register read not zero");

    outside_rom_pass_a: assert property (
        fetch.rd && !rpp_pkg::in_rom(fetch.addr)
        |=> !patch_hit && (code_rdata == $past(rom_rdata))
    )
    else $error("read outside rom was substituted");

    bank0_substitute_a: assert property (
        fetch.rd && rpp_pkg::in_rom(fetch.addr) && (fetch.addr[23:1] == bank[0].match_addr)
        |=> patch_hit && (patch_bank == 3'h0) && (code_rdata == $past(bank[0].patch_word))
    )
    else $error("bank0 match did not substitute");

    lowest_bank_wins_a: assert property (
        fetch.rd && match[1] && match[2] && !match[0] |=> patch_hit && (patch_bank == 3'h1)
    )
    else $error("lowest matching bank not chosen");

    no_wait_answer_a: assert property (
        fetch.rd |=> code_valid ##1 (code_valid == $past(fetch.rd))
    )
    else $error("fetch answer not on next cycle");

    hit_set_wins_a: assert property (
        fetch.rd && sel_hit && status_wr |=> hit_flags[$past(sel_index)]
    )
    else $error("hit lost against clear");

    reserved_offset_ignored_a: assert property (
        reg_wr && rpp_pkg::is_bank_addr(reg_addr) && (reg_addr[1:0] == 2'b11)
        |=> $stable({bank[0], bank[1], bank[2], bank[3], bank[4], bank[5]})
    )
    else $error("write to unused bank offset changed a bank");

    unmapped_write_ignored_a: assert property (
        reg_wr && !rpp_pkg::is_bank_addr(reg_addr)
        |=> $stable({bank[0], bank[1], bank[2], bank[3], bank[4], bank[5]})
    )
    else $error("write outside bank map changed a bank");

    addr_low_bank1_a: assert property (
        reg_wr && (reg_addr == rpp_pkg::BANK1_MATCH_ADDR_LOW)
        |=> bank[1].match_addr[7:1] == $past(reg_wdata[7:1])
    )
    else $error("bank1 low compare byte not stored");

    rom_miss_passes_a: assert property (
        fetch.rd && (match == '0)
        |=> !patch_hit && (patch_bank == 3'h0) && (code_rdata == $past(rom_rdata))
    )
    else $error("unmatched read did not return rom word");

    bank5_substitute_a: assert property (
        fetch.rd && match[5] && (match[4:0] == 5'h00)
        |=> patch_hit && (patch_bank == 3'h5) && (code_rdata == $past(bank[5].patch_word))
    )
    else $error("bank5 match did not substitute");

    answer_single_cycle_a: assert property (
        !fetch.rd
        |=> !code_valid
    )
    else $error("fetch answer without a request");

    answer_holds_idle_a: assert property (
        !fetch.rd
        |=> $stable(code_rdata) && $stable(patch_hit) && $stable(patch_bank)
    )
    else $error("fetch answer changed without a request");

    status_read_flags_a: assert property (
        reg_rd && (reg_addr == rpp_pkg::HIT_STATUS_ADDR)
        |=> reg_rdata == {2'b00, $past(hit_flags)}
    )
    else $error("status read did not return hit flags");

    other_read_zero_a: assert property (
        !(reg_rd && (reg_addr == rpp_pkg::HIT_STATUS_ADDR))
        |=> reg_rdata == rpp_pkg::READ_ZERO
    )
    else $error("read data not zero outside a status read");

    hit_flag_set_a: assert property (
        fetch.rd && sel_hit
        |=> hit_flags[$past(sel_index)]
    )
    else $error("hit flag not set by a substitution");

    hit_flag_clear_a: assert property (
        status_wr && !(fetch.rd && sel_hit)
        |=> ({2'b00, hit_flags} & $past(reg_wdata)) == 8'h00
    )
    else $error("hit flag not cleared by a one");

    hit_flag_hold_a: assert property (
        !status_wr && !(fetch.rd && sel_hit)
        |=> $stable(hit_flags)
    )
    else $error("hit flags changed with no event");

endmodule

// [testbench/rpp_rom_model.sv]
// code rom model answering the fetch side of the patch unit
`timescale 1ns/1ps
module rpp_rom_model
(
    input  wire rpp_pkg::rpp_fetch_t fetch,
    output logic [15:0]              rom_rdata
);
    // ==========================================
    // rom word per aligned pair; idle cycles show the inverted word
    always_comb
    begin
        if (fetch.rd)
            rom_rdata = fetch.addr[16:1] ^ 16'h5a3c;
        else
            rom_rdata = ~(fetch.addr[16:1] ^ 16'h5a3c);
    end
endmodule

// [testbench/tb_rom_program_patch_unit.sv]
// self-checking bench for the rom program patch unit
`timescale 1ns/1ps
module tb_rom_program_patch_unit;
    logic                sys_clk    = 1'b0;
    logic                rst_b      = 1'b0;
    logic [15:0]         reg_addr   = 16'h0000;
    logic [7:0]          reg_wdata  = 8'h00;
    logic                reg_wr     = 1'b0;
    logic                reg_rd     = 1'b0;
    rpp_pkg::rpp_fetch_t fetch      = '0;
    logic [7:0]          reg_rdata;
    logic [15:0]         rom_rdata;
    logic                code_valid;
    logic [15:0]         code_rdata;
    logic                patch_hit;
    logic [2:0]          patch_bank;
    logic [23:1]         m_addr [6];
    logic [15:0]         m_word [6];
    logic [5:0]          m_hit;
    logic [19:0]         q [$];
    logic [23:0]         ta [$];
    logic [19:0]         e;
    logic [19:0]         e2;
    logic [23:1]         pa;
    int                  n_mismatch = 0;
    int                  checks     = 0;
    int                  cyc        = 0;
    int                  seed       = 32'hbb9ca4a9;
    int                  bi;
    int                  k;

    always #4 sys_clk = ~sys_clk;

    rpp_patch_unit u_rpp_patch_unit
    (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch(fetch),
        .rom_rdata(rom_rdata), .code_valid(code_valid), .code_rdata(code_rdata),
        .patch_hit(patch_hit), .patch_bank(patch_bank)
    );

    rpp_rom_model u_rpp_rom_model
    (
        .fetch(fetch), .rom_rdata(rom_rdata)
    );

    // ==========================================
    // tasks
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        if (a >= 16'h0400 && a < 16'h0430 && a[2:0] == 3'h0)
            check({reg_rdata[7:1], x[0]}, x);
        else
            check(reg_rdata, x);
    endtask

    task automatic prog(input int b, input logic [23:1] a, input logic [15:0] w);
        logic [15:0] base;
        base = 16'h0400 + 16'(b * 8);
        wr(base, {a[7:1], 1'($random(seed))});
        wr(base + 16'h0001, a[15:8]);
        wr(base + 16'h0002, a[23:16]);
        wr(base + 16'h0004, w[7:0]);
        wr(base + 16'h0005, w[15:8]);
    endtask

    task automatic burst;
        foreach (ta[i])
        begin
            @(posedge sys_clk);
            fetch <= {1'b1, ta[i]};
        end
        @(posedge sys_clk);
        fetch <= {1'b0, 24'h000000};
        ta.delete();
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================
    // reference model of banks and fetch answers
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch++;
            wrap_up();
        end
        if (rst_b === 1'b1 && reg_wr === 1'b1 && reg_addr == rpp_pkg::HIT_STATUS_ADDR)
            m_hit = m_hit & ~reg_wdata[5:0];
        if (rst_b === 1'b1 && fetch.rd === 1'b1)
        begin
            e = {4'h0, rom_rdata};
            if (fetch.addr >= rpp_pkg::ROM_FIRST && fetch.addr <= rpp_pkg::ROM_LAST)
                for (int b = 5; b >= 0; b--)
                    if (m_addr[b] == fetch.addr[23:1])
                        e = {1'b1, 3'(b), m_word[b]};
            if (e[19])
                m_hit[e[18:16]] = 1'b1;
            q.push_back(e);
        end
        if (reg_wr === 1'b1 && reg_addr >= 16'h0400 && reg_addr < 16'h0430)
        begin
            bi = 32'(reg_addr - 16'h0400) >> 3;
            case (reg_addr[2:0])
                3'h0: m_addr[bi][7:1]   = reg_wdata[7:1];
                3'h1: m_addr[bi][15:8]  = reg_wdata;
                3'h2: m_addr[bi][23:16] = reg_wdata;
                3'h4: m_word[bi][7:0]   = reg_wdata;
                3'h5: m_word[bi][15:8]  = reg_wdata;
                default: ;
            endcase
        end
    end

    always @(negedge sys_clk)
        if (rst_b === 1'b1)
        begin
            if (q.size() > 0)
            begin
                e2 = q.pop_front();
                check(code_valid, 1'b1);
                check({patch_hit, patch_bank, code_rdata}, e2);
            end
            else
                check(code_valid, 1'b0);
        end

    // ==========================================
    // main sequence
    initial
    begin
        for (int b = 0; b < 6; b++)
        begin
            m_addr[b] = '0;
            m_word[b] = '0;
        end
        m_hit = '0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        ta = '{24'hff0000, 24'hff0001, 24'hffabcd, 24'h000000};
        burst();
        for (int a = 16'h0400; a < 16'h0430; a++)
            rd(16'(a), 8'h00);
        rd(16'h0600, 8'h00);
        $display("test reset done");
        for (int b = 0; b < 6; b++)
        begin
            pa = {8'hff, 15'($random(seed))};
            prog(b, pa, 16'($random(seed)));
            wr(16'h0403 + 16'(b * 8), 8'hff);
            ta.push_back({pa, 1'b0});
            ta.push_back({pa, 1'b1});
        end
        burst();
        rd(16'h0400, 8'h00);
        $display("test banks done");
        prog(4, m_addr[1], 16'h1234);
        prog(2, m_addr[1], 16'h5678);
        ta = '{{m_addr[1], 1'b0}};
        burst();
        pa = m_addr[2];
        prog(1, {8'hfe, 15'h7fff}, 16'h9abc);
        ta = '{{pa, 1'b1}, {pa, 1'b0}};
        burst();
        $display("test priority done");
        pa = {8'h12, m_addr[0][15:1]};
        prog(0, pa, 16'hbeef);
        ta = '{{pa, 1'b0}, {8'hff, pa[15:1], 1'b0}};
        burst();
        $display("test region done");
        repeat (300)
        begin
            k = {$random(seed)} % 8;
            if (k < 6)
                ta.push_back({m_addr[k], 1'($random(seed))});
            else
                ta.push_back(24'($random(seed)));
        end
        burst();
        $display("test random done");
        rd(16'h0440, {2'b00, m_hit});
        ta = '{{m_addr[3], 1'b0}};
        fork
            burst();
            wr(16'h0440, 8'h3f);
        join
        rd(16'h0440, {2'b00, m_hit});
        wr(16'h0440, 8'h3f);
        rd(16'h0440, 8'h00);
        $display("test status done");
        pa = m_addr[3];
        @(posedge sys_clk);
        rst_b <= 1'b0;
        for (int b = 0; b < 6; b++)
        begin
            m_addr[b] = '0;
            m_word[b] = '0;
        end
        m_hit = '0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        ta = '{{pa, 1'b0}};
        burst();
        rd(16'h0405, 8'h00);
        $display("test second reset done");
        wrap_up();
    end
endmodule
